/* src/spl_pkg.sv */
// Constants and types shared by the strapping pin latch files.
// Assumes a single 100 MHz clock domain.
package spl_pkg;
   localparam int  STRAP_COUNT          = 5;
   // Fixed bit positions of the latched straps
   localparam int  BIT_FLASH_VOLTAGE    = 0;
   localparam int  BIT_BOOT_SELECT      = 1;
   localparam int  BIT_BOOT_AUX         = 2;
   localparam int  BIT_LOG_AND_TIMING   = 3;
   localparam int  BIT_SDIO_OUTPUT_EDGE = 4;
   // Pull direction per strap: 1 pull-up, 0 pull-down
   localparam logic [4:0] PULL_UP_MASK  = 5'h1A;
   // Value of the latch before the first capture (the pull defaults)
   localparam logic [4:0] STRAP_RESET   = 5'h1A;
   // Regulator voltage select values
   localparam logic VSEL_FOLLOW_SUPPLY  = 1'h0;
   localparam logic VSEL_1V8            = 1'h1;
   // Edge select values
   localparam logic EDGE_FALLING        = 1'h0;
   localparam logic EDGE_RISING         = 1'h1;

   typedef enum logic [1:0] {
      BOOT_SPI_FLASH,
      BOOT_DOWNLOAD,
      BOOT_UNDEFINED
   } spl_boot_type;
endpackage

/* src/spl_strap_if.sv */
// Interface carrying latched straps between latch and decoder.
// Assumes both ends share clk.
`timescale 1ns/100ps
interface spl_strap_if;
   logic [4:0] strap_bits;
   logic       captured;
   modport latch  (output strap_bits, output captured);
   modport decode (input strap_bits, input captured);
endinterface

/* src/spl_capture.sv */
// Capture register for the five strapping pins.
// Assumes pin levels are synchronous to clk and reset releases cleanly.
`timescale 1ns/100ps
module spl_capture (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic [4:0] pin_level,
   spl_strap_if.latch      strap
);
   logic [4:0] bits_q;
   logic [4:0] bits_d;
   logic       done_q;
   logic       done_d;

   always_comb begin
      bits_d = bits_q;
      done_d = done_q;
      if (!done_q) begin
         bits_d = pin_level;   // First edge after release
         done_d = 1'b1;
      end
   end

   // Reset loads a constant; pins are caught by the clock after release
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         bits_q <= spl_pkg::STRAP_RESET;
         done_q <= 1'b0;
      end else begin
         bits_q <= bits_d;
         done_q <= done_d;
      end
   end

   assign strap.strap_bits = bits_q;
   assign strap.captured   = done_q;
endmodule

/* src/spl_decode.sv */
// Decodes latched straps into boot, log and timing settings.
// Assumes straps stand still once captured.
`timescale 1ns/100ps
module spl_decode (
   spl_strap_if.decode          strap,
   output spl_pkg::spl_boot_type boot_mode,
   output logic                  boot_log_enable,
   output logic                  strap_vsel,
   output logic                  strap_sample_edge,
   output logic                  strap_output_edge
);
   always_comb begin
      if (strap.strap_bits[spl_pkg::BIT_BOOT_SELECT])
         boot_mode = spl_pkg::BOOT_SPI_FLASH;
      else if (!strap.strap_bits[spl_pkg::BIT_BOOT_AUX])
         boot_mode = spl_pkg::BOOT_DOWNLOAD;
      else
         boot_mode = spl_pkg::BOOT_UNDEFINED;   // Combination not defined
   end

   assign boot_log_enable   = strap.strap_bits[spl_pkg::BIT_LOG_AND_TIMING];
   assign strap_vsel        = strap.strap_bits[spl_pkg::BIT_FLASH_VOLTAGE];
   assign strap_sample_edge = strap.strap_bits[spl_pkg::BIT_LOG_AND_TIMING];
   assign strap_output_edge = strap.strap_bits[spl_pkg::BIT_SDIO_OUTPUT_EDGE];
endmodule

/* src/spl_top.sv */
// Strapping pin latch: captures five straps at reset release, decodes them,
// and lets firmware override regulator voltage and SDIO timing.
// Assumes pins are synchronous to clk; resetn is the system reset.
// Operation
// - five strap bits readable after boot
// - sample pins at system reset release
// - hold bits until the next system reset
// - release pins to normal use afterward
// - weak pulls enabled during reset
// - voltage strap pulled down, 1 selects 1.8V
// - boot select pulled up, download needs zeros
// - log strap pulled up, 1 enables log
// - two straps choose SDIO sample, output edges
// - firmware overrides voltage and SDIO timing
// - regulator gives 1.8V or supply voltage
// - software can power regulator off
`timescale 1ns/100ps
module spl_top (
   input  wire logic                  clk,
   input  wire logic                  resetn,
   input  wire logic [4:0]            strap_pin_level,
   output logic [4:0]                 strap_pull_enable,
   output logic [4:0]                 strap_pull_up,
   output logic                       strap_config_mode,
   output logic [4:0]                 strap_value,
   output logic                       strap_valid,
   output spl_pkg::spl_boot_type      boot_mode,
   output logic                       boot_log_enable,
   input  wire logic                  fw_vsel_override,
   input  wire logic                  fw_vsel_value,
   input  wire logic                  fw_sdio_override,
   input  wire logic                  fw_sample_edge,
   input  wire logic                  fw_output_edge,
   input  wire logic                  fw_regulator_off,
   output logic                       regulator_enable,
   output logic                       regulator_vsel,
   output logic                       sdio_sample_edge,
   output logic                       sdio_output_edge
);
   spl_strap_if strap ();

   logic       strap_vsel;
   logic       strap_sample_edge;
   logic       strap_output_edge;
   logic       cfg_q;
   logic       cfg_d;
   logic       reg_en_q;
   logic       reg_en_d;
   logic       vsel_q;
   logic       vsel_d;
   logic       samp_q;
   logic       samp_d;
   logic       outp_q;
   logic       outp_d;

   spl_capture u_capture (
      .clk       (clk),
      .resetn    (resetn),
      .pin_level (strap_pin_level),
      .strap     (strap)
   );

   spl_decode u_decode (
      .strap             (strap),
      .boot_mode         (boot_mode),
      .boot_log_enable   (boot_log_enable),
      .strap_vsel        (strap_vsel),
      .strap_sample_edge (strap_sample_edge),
      .strap_output_edge (strap_output_edge)
   );

   assign strap_value = strap.strap_bits;
   assign strap_valid = strap.captured;

   // pulls during reset
   // Pulls stay on until the capture edge so the sampled level is settled
   always_comb begin
      cfg_d = 1'b0;   // release pins after capture
   end

   assign strap_config_mode = cfg_q;
   assign strap_pull_enable = cfg_q ? 5'h1F : 5'h00;
   assign strap_pull_up     = spl_pkg::PULL_UP_MASK;

   always_comb begin
      reg_en_d = !fw_regulator_off;
      vsel_d   = fw_vsel_override ? fw_vsel_value  : strap_vsel;
      samp_d   = fw_sdio_override ? fw_sample_edge : strap_sample_edge;
      outp_d   = fw_sdio_override ? fw_output_edge : strap_output_edge;
   end

   // Regulator and timing outputs registered; reset shows pull defaults
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cfg_q    <= 1'b1;
         reg_en_q <= 1'b1;
         vsel_q   <= spl_pkg::VSEL_FOLLOW_SUPPLY;
         samp_q   <= spl_pkg::EDGE_RISING;
         outp_q   <= spl_pkg::EDGE_RISING;
      end else begin
         cfg_q    <= cfg_d;
         reg_en_q <= reg_en_d;
         vsel_q   <= vsel_d;
         samp_q   <= samp_d;
         outp_q   <= outp_d;
      end
   end

   assign regulator_enable = reg_en_q;
   assign regulator_vsel   = vsel_q;
   assign sdio_sample_edge = samp_q;
   assign sdio_output_edge = outp_q;
endmodule

/* test/spl_top_checker.sv */
// Concurrent checks on the strap latch top ports.
// Assumes one clock domain and an async active-low reset.
`timescale 1ns/100ps
module spl_top_checker (
   input wire logic                  clk,
   input wire logic                  resetn,
   input wire logic [4:0]            strap_pin_level,
   input wire logic [4:0]            strap_pull_enable,
   input wire logic                  strap_config_mode,
   input wire logic [4:0]            strap_value,
   input wire logic                  strap_valid,
   input wire spl_pkg::spl_boot_type boot_mode,
   input wire logic                  boot_log_enable,
   input wire logic                  fw_regulator_off,
   input wire logic                  regulator_enable
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   cap_value_a: assert property (
      $rose(strap_valid) |-> strap_value == $past(strap_pin_level)) else $error("capture wrong");
   valid_soon_a: assert property (!strap_valid |=> strap_valid) else $error("valid late");
   hold_value_a: assert property (
      strap_valid && $past(strap_valid) |-> $stable(strap_value)) else $error("strap moved");
   pull_on_a: assert property (
      strap_config_mode |-> strap_pull_enable == 5'h1F) else $error("pulls off");
   pins_free_a: assert property (
      strap_valid |-> !strap_config_mode && strap_pull_enable == 5'h00) else $error("pins kept");
   log_bit_a: assert property (
      strap_valid |-> boot_log_enable == strap_value[3]) else $error("log wrong");
   boot_dl_a: assert property (strap_valid && strap_value[2:1] == 2'h0 |->
      boot_mode == spl_pkg::BOOT_DOWNLOAD) else $error("boot wrong");
   reg_off_a: assert property (
      strap_valid |-> regulator_enable == !$past(fw_regulator_off)) else $error("regulator wrong");
endmodule
bind spl_top spl_top_checker chk_u (.clk(clk), .resetn(resetn), .strap_pin_level(strap_pin_level),
   .strap_pull_enable(strap_pull_enable), .strap_config_mode(strap_config_mode), .strap_value(strap_value),
   .strap_valid(strap_valid), .boot_mode(boot_mode), .boot_log_enable(boot_log_enable),
   .fw_regulator_off(fw_regulator_off), .regulator_enable(regulator_enable));

/* test/spl_pin_host.sv */
// Far side of the strap pins: resistors or a host driving them.
// Assumes pull controls come straight from the latch top.
`timescale 1ns/100ps
module spl_pin_host (
   input wire logic       clk,
   input wire logic [4:0] pull_enable,
   input wire logic [4:0] pull_up,
   input wire logic [4:0] drive_en,
   input wire logic [4:0] drive_val,
   output logic [4:0]     pin_level
);
   logic [4:0] churn_q;
   // Unpulled floating pin wanders, so no stale level
   // Plain always: the start value comes from the initial block below
   initial churn_q = 5'h00;
   always @(posedge clk) churn_q <= ~churn_q;
   assign pin_level = (drive_en & drive_val) | (~drive_en & pull_enable & pull_up)
                    | (~drive_en & ~pull_enable & churn_q);
endmodule

/* test/tb_strapping_pin_latch.sv */
// Self-checking bench for the strap latch top.
// Assumes the pin host model on the strap pins.
`timescale 1ns/100ps
module tb_strapping_pin_latch;
   logic                  clk = 1'h0, resetn = 1'h0, cfg, vld, log_en, reg_en, vsel, se, oe;
   logic [4:0]            pins, pen, pup, val, s;
   logic [5:0]            den = 6'h00, dval = 6'h00, fw = 6'h00;
   logic [31:0]           seed = 32'h00017535;
   spl_pkg::spl_boot_type bm;
   int                    err_total = 0, checks_done = 0;
   always #5 clk = ~clk;
   spl_pin_host host_u (.clk(clk), .pull_enable(pen), .pull_up(pup), .drive_en(den[4:0]),
      .drive_val(dval[4:0]), .pin_level(pins));
   spl_top dut_u (.clk(clk), .resetn(resetn), .strap_pin_level(pins), .strap_pull_enable(pen),
      .strap_pull_up(pup), .strap_config_mode(cfg), .strap_value(val), .strap_valid(vld), .boot_mode(bm),
      .boot_log_enable(log_en), .fw_vsel_override(fw[0]), .fw_vsel_value(fw[1]), .fw_sdio_override(fw[2]),
      .fw_sample_edge(fw[3]), .fw_output_edge(fw[4]), .fw_regulator_off(fw[5]), .regulator_enable(reg_en),
      .regulator_vsel(vsel), .sdio_sample_edge(se), .sdio_output_edge(oe));
   function automatic logic [5:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[5:0];
   endfunction
   task automatic chk(input string n, input logic [4:0] seen, input logic [4:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("mismatches %0d checks %0d", err_total, checks_done);
      if (err_total == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Outputs decoded from the latched straps and firmware levels
   task automatic outs();
      chk("strap", val, s);
      chk("boot", {3'h0, bm}, s[1] ? 5'h00 : (s[2] ? 5'h02 : 5'h01));
      chk("decoded", {log_en, vsel, se, oe, reg_en}, {s[3], fw[0] ? fw[1] : s[0],
         fw[2] ? {fw[3], fw[4]} : {s[3], s[4]}, !fw[5]});
   endtask
   // Reset, capture random straps, then churn pins and firmware
   initial begin
      repeat (16) @(posedge clk);
      for (int r = 0; r < 40; r++) begin
         // Mid-run resets start on a rising edge, never between edges
         if (r > 0) @(posedge clk);
         resetn <= 1'h0;
         den <= xs();
         dval <= xs();
         fw <= xs();
         repeat (2) @(posedge clk);
         #1 chk("in reset", {pen[4:1], cfg}, 5'h1F);
         @(posedge clk) resetn <= 1'h1;
         s = (den[4:0] & dval[4:0]) | (~den[4:0] & 5'h1A);
         repeat (3) @(posedge clk);
         #1 chk("released", {pen[3:0], vld}, 5'h01);
         outs();
         for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            den <= xs();
            dval <= xs();
            fw <= xs();
            repeat (2) @(posedge clk);
            #1 outs();
         end
      end
      summarize();
   end
   // Cut a hang short
   initial begin
      #100000;
      err_total++;
      summarize();
   end
endmodule
